/* File: common/svm_pkg.sv */
// constants and types for the supply undervoltage monitor
// How it works
// (R1) With the power-down option set the comparator is ignored and neither flag nor reset is produced.
// (R2) An undervoltage reset is raised only while reset-disable is clear and the monitor is powered.
// (R3) In stop mode the monitor runs only when the stop-mode enable option is set.
// (R4) The trip-level select option picks the higher trip set when set and the lower one when clear.
// (R5) Once raised by the falling threshold, the reset holds until the supply is above the rising threshold.
// (R6) While the undervoltage reset is active the external active-low reset pin is driven low.
// (R7) The flag is 1 below the falling threshold, 0 above the rising one, and keeps its value between.
// (R8) Any system reset clears the flag and software writes to it have no effect.
// (R9) The monitor raises no processor interrupt; its outputs are the flag and the reset request. The code also drives o_evt_irq from the enabled event bits.
// (R10) For polling, software sets power-down to 0 and reset-disable to 1, then reads the flag.
// (R11) When enabled the monitor keeps working in wait mode without the processor clock.
// (R12) An undervoltage reset raised in wait, or in stop with stop operation on, ends the low-power mode.
// (R13) After power-on reset the configuration bits come from the first option register.
// (R14) On leaving an undervoltage reset the processor fetches its start address from the reset vector pair.
// (R15) Both comparator inputs are synchronised before the flag or reset logic uses them.
package svm_pkg;

   localparam int          SVM_AW            = 5;
   localparam int          SVM_DW            = 32;

   // byte offsets on the register bus
   localparam logic [4:0]  SVM_OFS_STATUS    = 5'h00;
   localparam logic [4:0]  SVM_OFS_OPTION    = 5'h04;
   localparam logic [4:0]  SVM_OFS_EVT_STAT  = 5'h08;
   localparam logic [4:0]  SVM_OFS_EVT_CLR   = 5'h0C;
   localparam logic [4:0]  SVM_OFS_EVT_EN    = 5'h10;

   // supply_monitor_status fields
   localparam int          SVM_ST_FLAG       = 0;
   localparam int          SVM_ST_RST_ACT    = 1;
   localparam int          SVM_ST_MON_ACT    = 2;
   localparam int          SVM_ST_BELOW      = 3;

   // option_register_one fields
   localparam int          SVM_OPT_PWR_DOWN  = 0;
   localparam int          SVM_OPT_RST_DIS   = 1;
   localparam int          SVM_OPT_STOP_EN   = 2;
   localparam int          SVM_OPT_TRIP_SEL  = 3;
   localparam logic [3:0]  SVM_OPT_RESET     = 4'h0;

   // event bits
   localparam int          SVM_EV_FLAG_SET   = 0;
   localparam int          SVM_EV_FLAG_CLR   = 1;
   localparam int          SVM_EV_UV_RESET   = 2;
   localparam int          SVM_EV_W          = 3;

   localparam logic [15:0] SVM_RESET_VECTOR  = 16'hFFFE;
   localparam logic [2:0]  SVM_SYNC_RESET    = 3'h0;

   typedef enum logic [0:0] {
      SVM_UV_IDLE = 1'b0,
      SVM_UV_HOLD = 1'b1
   } svm_uv_e;

   typedef struct packed {
      logic [2:0]        sync_below;
      logic [2:0]        sync_above;
      logic              below;
      logic              above;
      logic [3:0]        option;
      logic              flag;
      svm_uv_e           uv_state;
      logic [SVM_EV_W-1:0] evt_stat;
      logic [SVM_EV_W-1:0] evt_en;
      logic              irq;
      logic              sys_rst_req;
      logic              pin_oe;
      logic              pin_out;
      logic              trip_sel;
      logic              comp_en;
      logic              lp_exit;
      logic [15:0]       vector;
      logic              uv_source;
      logic              waitreq;
      logic [SVM_DW-1:0] rdata;
   } svm_state_s;

endpackage

/* File: hdl/svm_top.sv */
// supply undervoltage monitor: flag, reset request and register slave
//
// Added by the designer: register access over Avalon-MM and the register addresses.
module svm_top
   import svm_pkg::*;
(
   input  wire logic              I_CLK,
   input  wire logic              I_RST_N,
   input  wire logic              i_below_falling_trip,
   input  wire logic              i_above_rising_trip,
   input  wire logic              i_sys_reset,
   input  wire logic              i_wait_mode,
   input  wire logic              i_stop_mode,
   input  wire logic [SVM_AW-1:0] i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [SVM_DW-1:0] i_avs_writedata,
   input  wire logic [3:0]        i_avs_byteenable,
   output logic [SVM_DW-1:0]      o_avs_readdata,
   output logic                   o_avs_waitrequest,
   output logic                   o_undervoltage_flag,
   output logic                   o_sys_reset_req,
   output logic                   o_rst_pin_out,
   output logic                   o_rst_pin_oe,
   output logic                   o_trip_level_select,
   output logic                   o_comparator_enable,
   output logic                   o_lowpower_exit,
   output logic [15:0]            o_reset_vector,
   output logic                   o_reset_from_undervoltage,
   output logic                   o_evt_irq
);

   svm_state_s st;
   svm_state_s next_st;

   logic       pwr_down;
   logic       rst_dis;
   logic       stop_en;
   logic       mon_active;
   logic       req;
   logic       accept;
   logic       write_hit;
   logic [SVM_EV_W-1:0] ev_set;
   logic [SVM_EV_W-1:0] ev_clr;
   logic [SVM_DW-1:0]   rd_mux;
   logic [7:0]          status;

   assign pwr_down   = st.option[SVM_OPT_PWR_DOWN];
   assign rst_dis    = st.option[SVM_OPT_RST_DIS];
   assign stop_en    = st.option[SVM_OPT_STOP_EN];
   // powered, and either not stopped or allowed to run in stop; wait mode never gates it
   assign mon_active = !pwr_down && !(i_stop_mode && !stop_en); // R1 R3 R11
   assign req        = i_avs_read || i_avs_write;
   // a request completes at the edge where waitrequest is low
   assign accept     = req && !st.waitreq;
   assign write_hit  = accept && i_avs_write && i_avs_byteenable[0];

   assign status = {4'h0, st.below, mon_active, (st.uv_state == SVM_UV_HOLD), st.flag};

   always_comb begin
      rd_mux = '0;
      case (i_avs_address)
         SVM_OFS_STATUS: begin
            rd_mux[7:0] = status;
         end
         SVM_OFS_OPTION: begin
            rd_mux[3:0] = st.option;
         end
         SVM_OFS_EVT_STAT: begin
            rd_mux[SVM_EV_W-1:0] = st.evt_stat;
         end
         SVM_OFS_EVT_EN: begin
            rd_mux[SVM_EV_W-1:0] = st.evt_en;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   always_comb begin
      next_st = st;
      ev_set  = '0;
      ev_clr  = '0;

      // three-stage capture; a level counts once stages two and three agree
      next_st.sync_below = {st.sync_below[1:0], i_below_falling_trip}; // R15
      next_st.sync_above = {st.sync_above[1:0], i_above_rising_trip}; // R15
      if (st.sync_below[1] == st.sync_below[2]) begin
         next_st.below = st.sync_below[2]; // R15
      end
      if (st.sync_above[1] == st.sync_above[2]) begin
         next_st.above = st.sync_above[2]; // R15
      end

      // flag follows the comparator with hysteresis, only while monitoring
      if (i_sys_reset) begin
         next_st.flag = 1'b0; // R8
      end else if (mon_active) begin // R1
         if (st.below) begin
            next_st.flag = 1'b1; // R7
         end else if (st.above) begin
            next_st.flag = 1'b0; // R7
         end
      end
      ev_set[SVM_EV_FLAG_SET] = next_st.flag && !st.flag;
      ev_set[SVM_EV_FLAG_CLR] = !next_st.flag && st.flag && !i_sys_reset;

      // undervoltage reset with hysteresis
      next_st.lp_exit = 1'b0;
      case (st.uv_state)
         SVM_UV_IDLE: begin
            if (mon_active && !rst_dis && st.below) begin // R2
               next_st.uv_state = SVM_UV_HOLD;
               ev_set[SVM_EV_UV_RESET] = 1'b1;
               // wake from wait, or from stop when stop operation is on
               next_st.lp_exit = i_wait_mode || (i_stop_mode && stop_en); // R12
            end
         end
         SVM_UV_HOLD: begin
            if (!mon_active || rst_dis) begin
               next_st.uv_state = SVM_UV_IDLE; // R1 R2
            end else if (st.above && !st.below) begin
               next_st.uv_state = SVM_UV_IDLE; // R5
            end
         end
         default: begin
            next_st.uv_state = SVM_UV_IDLE;
         end
      endcase

      // the reset request out of the block, mirrored on the reset pin below; no processor interrupt vector exists
      next_st.sys_rst_req = (next_st.uv_state == SVM_UV_HOLD); // R9 R5
      next_st.pin_oe      = (next_st.uv_state == SVM_UV_HOLD); // R6
      next_st.pin_out     = 1'b0; // R6
      if (next_st.uv_state == SVM_UV_HOLD) begin
         next_st.vector    = SVM_RESET_VECTOR; // R14
         next_st.uv_source = 1'b1; // R14
      end else if (i_sys_reset == 1'b0 && st.uv_state == SVM_UV_IDLE && st.uv_source && accept) begin
         next_st.uv_source = 1'b0;
      end

      next_st.trip_sel = st.option[SVM_OPT_TRIP_SEL]; // R4
      next_st.comp_en  = mon_active; // R1 R3 R11

      // bus slave: one wait cycle, then the answer
      next_st.waitreq = 1'b1;
      if (req && st.waitreq) begin
         next_st.waitreq = 1'b0;
         next_st.rdata   = i_avs_read ? rd_mux : '0;
      end
      if (write_hit) begin
         case (i_avs_address)
            SVM_OFS_OPTION: begin
               next_st.option = i_avs_writedata[3:0]; // R10 R13
            end
            SVM_OFS_EVT_CLR: begin
               ev_clr = i_avs_writedata[SVM_EV_W-1:0];
            end
            SVM_OFS_EVT_EN: begin
               next_st.evt_en = i_avs_writedata[SVM_EV_W-1:0];
            end
            default: begin
               next_st.option = st.option; // R8
            end
         endcase
      end

      // sticky events: a set in the clearing cycle wins
      next_st.evt_stat = (st.evt_stat & ~ev_clr) | ev_set;
      next_st.irq      = |(next_st.evt_stat & next_st.evt_en);
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st.sync_below  <= SVM_SYNC_RESET;
         st.sync_above  <= SVM_SYNC_RESET;
         st.below       <= 1'b0;
         st.above       <= 1'b0;
         st.option      <= SVM_OPT_RESET; // R13
         st.flag        <= 1'b0; // R8
         st.uv_state    <= SVM_UV_IDLE;
         st.evt_stat    <= '0;
         st.evt_en      <= '0;
         st.irq         <= 1'b0;
         st.sys_rst_req <= 1'b0;
         st.pin_oe      <= 1'b0;
         st.pin_out     <= 1'b0;
         st.trip_sel    <= SVM_OPT_RESET[SVM_OPT_TRIP_SEL];
         st.comp_en     <= 1'b0;
         st.lp_exit     <= 1'b0;
         st.vector      <= SVM_RESET_VECTOR;
         st.uv_source   <= 1'b0;
         st.waitreq     <= 1'b1;
         st.rdata       <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_avs_readdata            = st.rdata;
   assign o_avs_waitrequest         = st.waitreq;
   assign o_undervoltage_flag       = st.flag;
   assign o_sys_reset_req           = st.sys_rst_req;
   assign o_rst_pin_out             = st.pin_out;
   assign o_rst_pin_oe              = st.pin_oe;
   assign o_trip_level_select       = st.trip_sel;
   assign o_comparator_enable       = st.comp_en;
   assign o_lowpower_exit           = st.lp_exit;
   assign o_reset_vector            = st.vector;
   assign o_reset_from_undervoltage = st.uv_source;
   assign o_evt_irq                 = st.irq;

endmodule

/* File: sim/svm_checker.sv */
// concurrent checks on the supply monitor top ports
module svm_checker
(
   input wire logic        I_CLK,
   input wire logic        I_RST_N,
   input wire logic        i_below_falling_trip,
   input wire logic        i_above_rising_trip,
   input wire logic        i_sys_reset,
   input wire logic        i_stop_mode,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic        o_avs_waitrequest,
   input wire logic        o_undervoltage_flag,
   input wire logic        o_sys_reset_req,
   input wire logic        o_rst_pin_out,
   input wire logic        o_rst_pin_oe,
   input wire logic        o_comparator_enable,
   input wire logic        o_lowpower_exit,
   input wire logic [15:0] o_reset_vector
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   sequence req_seen;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   // seven samples cover the synchroniser and flag latency
   sequence low_steady;
      (i_below_falling_trip && !i_above_rising_trip && o_comparator_enable && !i_sys_reset)[*7];
   endsequence
   sequence high_steady;
      (i_above_rising_trip && !i_below_falling_trip && o_comparator_enable)[*7];
   endsequence
   sequence hold_cond;
      (o_sys_reset_req && !i_above_rising_trip && !i_avs_write && !i_stop_mode)[*6];
   endsequence
   AST_BUS_ANSWER: assert property (req_seen |=> !o_avs_waitrequest) else $error("bus answer late");
   AST_FLAG_SET: assert property (low_steady |-> o_undervoltage_flag) else $error("flag not set");
   AST_FLAG_CLR: assert property (high_steady |-> !o_undervoltage_flag) else $error("flag not clear");
   AST_SYS_CLEAR: assert property (i_sys_reset |=> !o_undervoltage_flag) else $error("flag kept");
   AST_RST_HOLD: assert property (hold_cond |=> o_sys_reset_req) else $error("reset dropped");
   AST_PIN_LOW: assert property (o_rst_pin_oe == o_sys_reset_req && !o_rst_pin_out)
      else $error("reset pin wrong");
   AST_EXIT_PULSE: assert property (o_lowpower_exit |=> !o_lowpower_exit) else $error("exit too long");
   AST_VECTOR: assert property (o_reset_vector == 16'hFFFE) else $error("vector wrong");
endmodule

bind svm_top svm_checker svm_checker_inst (.I_CLK, .I_RST_N, .i_below_falling_trip, .i_above_rising_trip,
   .i_sys_reset, .i_stop_mode, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .o_undervoltage_flag,
   .o_sys_reset_req, .o_rst_pin_out, .o_rst_pin_oe, .o_comparator_enable, .o_lowpower_exit, .o_reset_vector);

/* File: sim/svm_cmp_model.sv */
// supply comparator model with two trip sets
module svm_cmp_model #(
   parameter int HI_FALL = 4300,
   parameter int HI_RISE = 4450,
   parameter int LO_FALL = 2600,
   parameter int LO_RISE = 2750
) (
   input  wire logic               i_trip_sel,
   input  wire logic signed [31:0] i_supply_mv,
   output logic                    o_below,
   output logic                    o_above
);
   timeunit 1ns;
   timeprecision 100ps;
   always_comb begin
      o_below = i_supply_mv < (i_trip_sel ? HI_FALL : LO_FALL);
      o_above = i_supply_mv > (i_trip_sel ? HI_RISE : LO_RISE);
   end
endmodule

/* File: sim/svm_tb_top.sv */
// self-checking bench for the supply undervoltage monitor
module svm_tb_top
   import svm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HF = 4300, HR = 4450, LF = 2600, LR = 2750;
   localparam logic [4:0] ADRS [5] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h14};
   localparam int EXPS [5] = '{4, 0, 0, 0, 0};
   logic clk = 0, rst_n = 0, below, above, sys_rst = 0, wt = 0, stp = 0, rd = 0, wr = 0;
   logic [4:0] adr = 0;
   logic [31:0] wd = 0, q, rdat;
   logic wreq, flag, rreq, pout, poe, tsel, cen, lpx, rfuv, irq, saw_exit = 0;
   logic [15:0] vec;
   int supply = 5000, error_cnt = 0, check_count = 0, flag_m = 0, rst_m = 0, opt_m = 0;
   bit [31:0] lfsr = 91124;
   svm_top svm_top_inst (.I_CLK(clk), .I_RST_N(rst_n), .i_below_falling_trip(below), .i_above_rising_trip(above),
      .i_sys_reset(sys_rst), .i_wait_mode(wt), .i_stop_mode(stp), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .o_undervoltage_flag(flag), .o_sys_reset_req(rreq), .o_rst_pin_out(pout),
      .o_rst_pin_oe(poe), .o_trip_level_select(tsel), .o_comparator_enable(cen), .o_lowpower_exit(lpx),
      .o_reset_vector(vec), .o_reset_from_undervoltage(rfuv), .o_evt_irq(irq));
   svm_cmp_model #(.HI_FALL(HF), .HI_RISE(HR), .LO_FALL(LF), .LO_RISE(LR)) svm_cmp_model_inst (.i_trip_sel(tsel),
      .i_supply_mv(supply), .o_below(below), .o_above(above));
   initial forever #2.5 clk = ~clk;
   // exit is a one-cycle pulse, so catch it here
   always @(posedge clk) if (lpx === 1'b1) saw_exit <= 1;
   function int rnd(int m);
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return int'(lfsr % m);
   endfunction
   task conclude;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task bus(bit w, logic [4:0] a, logic [31:0] d);
      int n;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      q = rdat;
      rd <= 0;
      wr <= 0;
      if (n >= 40) begin
         error_cnt++;
         conclude;
      end
   endtask
   task opt(int v);
      bus(1, SVM_OFS_OPTION, v);
      opt_m = v;
   endtask
   task irqchk(int e);
      repeat (3) @(posedge clk);
      chk("irq", e, irq);
   endtask
   task step(int v);
      int f, r;
      bit act;
      @(posedge clk);
      supply <= v;
      repeat (8) @(posedge clk);
      f = opt_m[3] ? HF : LF;
      r = opt_m[3] ? HR : LR;
      act = !opt_m[0] && !(stp && !opt_m[2]);
      if (act && v < f) flag_m = 1;
      if (act && v > r) flag_m = 0;
      if (act && !opt_m[1] && v < f) rst_m = 1;
      if (!act || opt_m[1] || v > r) rst_m = 0;
      chk("flag", flag_m, flag);
      chk("reset", rst_m, rreq);
      chk("pin_oe", rst_m, poe);
      chk("pin_out", 0, pout);
      chk("mon_en", act, cen);
      chk("trip", opt_m[3], tsel);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 5; i++) begin
         bus(0, ADRS[i], 0);
         chk("reg", EXPS[i], q);
      end
      bus(1, SVM_OFS_STATUS, rnd(256));
      bus(0, SVM_OFS_STATUS, 0);
      chk("status", 4, q);
      chk("vector", 16'hFFFE, vec);
      bus(1, SVM_OFS_EVT_EN, 7);
      @(posedge clk) wt <= 1;
      step(2000);
      chk("lp_exit", 1, saw_exit);
      @(posedge clk) wt <= 0;
      saw_exit <= 0;
      step(2700);
      step(3000);
      chk("uv_src", 1, rfuv);
      bus(0, SVM_OFS_EVT_STAT, 0);
      chk("events", 7, q);
      irqchk(1);
      chk("uv_src", 0, rfuv);
      bus(1, SVM_OFS_EVT_EN, 0);
      irqchk(0);
      bus(1, SVM_OFS_EVT_EN, 7);
      irqchk(1);
      bus(1, SVM_OFS_EVT_CLR, 7);
      irqchk(0);
      @(posedge clk) stp <= 1;
      step(2000);
      chk("lp_exit", 0, saw_exit);
      step(5000);
      opt(4);
      step(2000);
      chk("lp_exit", 1, saw_exit);
      step(5000);
      @(posedge clk) stp <= 0;
      opt(1);
      step(2000);
      step(5000);
      repeat (30) begin
         opt(2 + 8 * rnd(2));
         step(supply);
         step(2000 + rnd(3000));
      end
      opt(2);
      step(2000);
      step(2700);
      @(posedge clk) sys_rst <= 1;
      @(posedge clk) sys_rst <= 0;
      flag_m = 0;
      step(2700);
      conclude;
   end
endmodule
